//--- rtl/dwc_consts.svh
`ifndef DWC_CONSTS_SVH
`define DWC_CONSTS_SVH
// register addresses
`define DWC_ADDR_NV         24'h000005
`define DWC_ADDR_VOL        24'h070005
// field positions
`define DWC_DRV_HI          7
`define DWC_DRV_LO          5
`define DWC_SLEEP_BIT       2
`define DWC_RSV3_BIT        3
// factory value of the register: 45 ohm, standby, bit 3 set
`define DWC_FACTORY         8'h08
// mask of host-writable bits and forced-one bits
`define DWC_WR_MASK         8'hE4
`define DWC_FORCE_ONE       8'h08
// timing, in ns, and derived cycle counts at 25 ns
`define DWC_CLK_NS          25
`define DWC_WAKE_PULSE_NS   100
`define DWC_WAKE_CYC        ((`DWC_WAKE_PULSE_NS + `DWC_CLK_NS - 1) / `DWC_CLK_NS)
`define DWC_EXIT_NS         10000
`define DWC_EXIT_CYC        ((`DWC_EXIT_NS + `DWC_CLK_NS - 1) / `DWC_CLK_NS)
`endif

//--- rtl/dwc_pkg.sv
package dwc_pkg;
   // power state of the device
   typedef enum logic [1:0]
   {
      DWC_RESET   = 2'b00,
      DWC_STANDBY = 2'b01,
      DWC_SLEEP   = 2'b10,
      DWC_WAKING  = 2'b11
   } dwc_power_e;
endpackage

//--- rtl/dwc_sync_if.sv
`timescale 1ns/1ps
// carries synchronised pin levels from the synchroniser to the top
interface dwc_sync_if;
   logic csHigh;   // chip select deasserted, synchronised
   logic rstPinN;  // hardware reset pin, synchronised, active low
   modport src (output csHigh, output rstPinN);
   modport dst (input csHigh, input rstPinN);
endinterface

//--- rtl/dwc_sync.sv
`timescale 1ns/1ps
// =====================================================
// two-flop synchroniser for the asynchronous pins
module dwc_sync
(
   input  wire logic ref_clk,
   input  wire logic rst_n,
   input  wire logic csPinN,
   input  wire logic hwResetPinN,
   dwc_sync_if.src   syncOut
);
   logic [1:0] stage1_ff;      // first stage, read only by stage 2
   logic [1:0] stage2_ff;      // second stage
   logic [1:0] nxt_stage1;
   logic [1:0] nxt_stage2;

   // next values: shift pins through
   always_comb
   begin
      nxt_stage1 = {csPinN, hwResetPinN};
      nxt_stage2 = stage1_ff;
   end

   // reset to idle levels: cs high, reset pin released
   always_ff @(posedge ref_clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         stage1_ff <= 2'h3;
         stage2_ff <= 2'h3;
      end
      else
      begin
         stage1_ff <= nxt_stage1;
         stage2_ff <= nxt_stage2;
      end
   end

   assign syncOut.csHigh  = stage2_ff[1];
   assign syncOut.rstPinN = stage2_ff[0];
endmodule // dwc_sync

//--- rtl/dwc_config_reg.sv
`timescale 1ns/1ps
`include "dwc_consts.svh"
// Behaviour
// - three-bit select sets output drive impedance
// - factory default select is 45 ohm
// - sleep bit set, cs high: reset from power-on or standby ends in deep sleep
// - sleep bit clear: reset ends in standby
// - hibernate exit obeys same sleep choice
// - cs pulse or reset pin wakes after exit time
// - wake pulse uses chip select only
// - software reset from standby or sleep always ends in standby
// - bits 4,1,0 read zero, bit 3 one
// - drive select and sleep bit are read-write
// - write at volatile address; read back contents
module dwc_config_reg
(
   input  wire logic       ref_clk,
   input  wire logic       rst_n,          // power-on reset
   input  wire logic       csPinN,         // chip select pin, async
   input  wire logic       hwResetPinN,    // hardware reset pin, async
   input  wire logic       busResetReq,    // bus-signalled reset, decoder pulse
   input  wire logic       softResetReq,   // software reset, decoder pulse
   input  wire logic       hibernateExit,  // hibernate exit, decoder pulse
   input  wire logic       wrStrobe,       // any-register write, decoder pulse
   input  wire logic [23:0] wrAddr,        // register address of the write
   input  wire logic [7:0] wrData,         // data byte of the write
   input  wire logic [7:0] nvImage,        // nonvolatile copy contents
   output logic      [7:0] rdData,         // register contents for reads
   output logic      [2:0] driveStrengthSelect, // pad drive select
   output logic            deepSleep,      // device in deepest sleep state
   output logic            standby         // device in standby
);
   // =====================================================
   // synchronised pins
   dwc_sync_if syncBus ();

   dwc_sync u_sync
   (
      .ref_clk     (ref_clk),
      .rst_n       (rst_n),
      .csPinN      (csPinN),
      .hwResetPinN (hwResetPinN),
      .syncOut     (syncBus.src)
   );

   // =====================================================
   // state
   localparam int WAKE_CYC = `DWC_WAKE_CYC;
   localparam int EXIT_CYC = `DWC_EXIT_CYC;

   logic [7:0]              cfg_ff;          // volatile register copy
   logic [7:0]              nxt_cfg;
   dwc_pkg::dwc_power_e     pwr_ff;          // power state
   dwc_pkg::dwc_power_e     nxt_pwr;
   logic [13:0]             cnt_ff;          // pulse / exit counter
   logic [13:0]             nxt_cnt;
   logic                    rstPinD_ff;      // previous reset pin level
   logic                    nxt_rstPinD;
   logic                    pulseOk_ff;      // cs low long enough
   logic                    nxt_pulseOk;
   logic [7:0]              rdData_ff;
   logic [7:0]              nxt_rdData;
   logic                    deep_ff;
   logic                    nxt_deep;
   logic                    stby_ff;
   logic                    nxt_stby;
   logic                    hwResetLow;      // reset pin held low
   logic                    hwResetRise;     // reset pin just released
   logic                    hwResetDone;     // any hardware reset completes

   assign hwResetLow  = !syncBus.rstPinN;
   assign hwResetRise = syncBus.rstPinN && !rstPinD_ff;
   assign hwResetDone = hwResetRise || busResetReq;

   // sanitise a byte: keep writable bits, force reserved values
   function automatic logic [7:0] clean(input logic [7:0] v);
      clean = (v & `DWC_WR_MASK) | `DWC_FORCE_ONE;
   endfunction

   // =====================================================
   // next-state logic
   always_comb
   begin
      nxt_cfg     = cfg_ff;
      nxt_pwr     = pwr_ff;
      nxt_cnt     = cnt_ff;
      nxt_pulseOk = pulseOk_ff;
      nxt_rstPinD = syncBus.rstPinN;
      // reload from nonvolatile copy on hardware reset
      if (hwResetLow || busResetReq)
         nxt_cfg = clean(nvImage);
      else if (wrStrobe && wrAddr == `DWC_ADDR_VOL)
         nxt_cfg = clean(wrData);
      unique case (pwr_ff)
         dwc_pkg::DWC_RESET:
         begin
            // first cycle after power-on: copy loaded, pick state
            nxt_cfg = clean(nvImage);
            nxt_pwr = (nvImage[`DWC_SLEEP_BIT] && syncBus.csHigh) ?
                      dwc_pkg::DWC_SLEEP : dwc_pkg::DWC_STANDBY;
         end
         dwc_pkg::DWC_STANDBY, dwc_pkg::DWC_SLEEP:
         begin
            // wake pulse timed from cs alone; clock and data ignored
            if (pwr_ff == dwc_pkg::DWC_SLEEP && !syncBus.csHigh)
            begin
               // the last low cycle of the width sets the flag, so an exact-width pulse wakes
               if (cnt_ff < 14'(WAKE_CYC - 1))
                  nxt_cnt = cnt_ff + 14'h1;
               else
                  nxt_pulseOk = 1'b1;
            end
            else
               nxt_cnt = '0;
            if (pwr_ff == dwc_pkg::DWC_SLEEP && syncBus.csHigh && pulseOk_ff)
            begin
               nxt_pwr     = dwc_pkg::DWC_WAKING;
               nxt_cnt     = '0;
               nxt_pulseOk = 1'b0;
            end
            if (softResetReq)
            begin
               nxt_pwr = dwc_pkg::DWC_STANDBY;
               nxt_cnt = '0;
               nxt_pulseOk = 1'b0;
            end
            else if (hwResetDone || hibernateExit)
            begin
               // sleep choice uses the copy being loaded now
               nxt_pwr = (nxt_cfg[`DWC_SLEEP_BIT] && syncBus.csHigh) ?
                         dwc_pkg::DWC_SLEEP : dwc_pkg::DWC_STANDBY;
               nxt_cnt = '0;
               nxt_pulseOk = 1'b0;
            end
            else if (pwr_ff == dwc_pkg::DWC_SLEEP && hwResetLow)
            begin
               nxt_pwr = dwc_pkg::DWC_WAKING;
               nxt_cnt = '0;
            end
         end
         dwc_pkg::DWC_WAKING:
         begin
            // exit time elapses before standby
            if (cnt_ff >= 14'(EXIT_CYC - 1))
            begin
               nxt_pwr = dwc_pkg::DWC_STANDBY;
               nxt_cnt = '0;
            end
            else
               nxt_cnt = cnt_ff + 14'h1;
         end
      endcase
      nxt_rdData = nxt_cfg;
      nxt_deep   = (nxt_pwr == dwc_pkg::DWC_SLEEP);
      nxt_stby   = (nxt_pwr == dwc_pkg::DWC_STANDBY);
   end

   // =====================================================
   // registers; factory value until first load
   always_ff @(posedge ref_clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         cfg_ff     <= `DWC_FACTORY;
         pwr_ff     <= dwc_pkg::DWC_RESET;
         cnt_ff     <= '0;
         rstPinD_ff <= 1'b1;
         pulseOk_ff <= 1'b0;
         rdData_ff  <= `DWC_FACTORY;
         deep_ff    <= 1'b0;
         stby_ff    <= 1'b0;
      end
      else
      begin
         cfg_ff     <= nxt_cfg;
         pwr_ff     <= nxt_pwr;
         cnt_ff     <= nxt_cnt;
         rstPinD_ff <= nxt_rstPinD;
         pulseOk_ff <= nxt_pulseOk;
         rdData_ff  <= nxt_rdData;
         deep_ff    <= nxt_deep;
         stby_ff    <= nxt_stby;
      end
   end

   // outputs straight from flops; the select drives pad impedance
   assign rdData              = rdData_ff;
   assign driveStrengthSelect = rdData_ff[`DWC_DRV_HI:`DWC_DRV_LO];
   assign deepSleep           = deep_ff;
   assign standby             = stby_ff;

   // =====================================================
   // checks
   sequence wakeStart_s;
      pwr_ff == dwc_pkg::DWC_SLEEP ##1 pwr_ff == dwc_pkg::DWC_WAKING;
   endsequence

   rsv_bits_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
      (rdData[4] == 1'b0 && rdData[1:0] == 2'h0 && rdData[3] == 1'b1))
      else $error("reserved bits wrong");
   soft_rst_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
      (softResetReq && pwr_ff != dwc_pkg::DWC_RESET && pwr_ff != dwc_pkg::DWC_WAKING)
      |=> standby)
      else $error("soft reset not standby");
   vol_write_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
      (wrStrobe && wrAddr == `DWC_ADDR_VOL && !hwResetLow && !busResetReq
       && pwr_ff != dwc_pkg::DWC_RESET)
      |=> rdData == clean($past(wrData)))
      else $error("volatile write lost");
   drive_out_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
      (wrStrobe && wrAddr == `DWC_ADDR_VOL && !hwResetLow && !busResetReq
       && pwr_ff != dwc_pkg::DWC_RESET)
      |=> driveStrengthSelect == $past(wrData[`DWC_DRV_HI:`DWC_DRV_LO]))
      else $error("drive select not written");
   nv_load_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
      (busResetReq && pwr_ff != dwc_pkg::DWC_RESET) |=> cfg_ff == clean($past(nvImage)))
      else $error("nv reload missing");
   sleep_sel_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
      (hibernateExit && !softResetReq && !busResetReq && !hwResetLow && syncBus.csHigh
       && (pwr_ff == dwc_pkg::DWC_STANDBY || pwr_ff == dwc_pkg::DWC_SLEEP))
      |=> deepSleep == $past(cfg_ff[`DWC_SLEEP_BIT]))
      else $error("hibernate exit state wrong");
   por_sel_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
      (pwr_ff == dwc_pkg::DWC_RESET && !nvImage[`DWC_SLEEP_BIT]) |=> standby)
      else $error("por not standby");
   exit_time_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
      wakeStart_s |-> !standby [*8])
      else $error("woke too early");
endmodule // dwc_config_reg

//--- tb/dwc_host_model.sv
`timescale 1ns/1ps
`include "dwc_consts.svh"
// ========================================
// host stand-in: chip select and decoded writes
module dwc_host_model
(
   input  wire logic        ref_clk,
   output logic             csPinN,    // idles high
   output logic             wrStrobe,  // one-cycle pulse
   output logic [23:0]      wrAddr,    // register address
   output logic [7:0]       wrData     // data byte
);
   // idle bus holds a pattern that is no register address
   initial
   begin
      csPinN   = 1'b1;
      wrStrobe = 1'b0;
      wrAddr   = 24'hA5A5A5;
      wrData   = 8'h5A;
   end
   // ========================================
   // one write; bit 3 always goes out as one
   task automatic writeReg(input logic [23:0] addr, input logic [7:0] data);
      @(posedge ref_clk);
      wrStrobe <= 1'b1;
      wrAddr   <= addr;
      wrData   <= data | `DWC_FORCE_ONE;
      @(posedge ref_clk);
      wrStrobe <= 1'b0;
      // released lines invert so a stale byte never looks valid
      wrAddr   <= ~addr;
      wrData   <= ~(data | `DWC_FORCE_ONE);
   endtask
   // chip select alone, no clock or data activity
   task automatic wakePulse(input int cycles);
      @(posedge ref_clk);
      csPinN <= 1'b0;
      repeat (cycles) @(posedge ref_clk);
      csPinN <= 1'b1;
   endtask
endmodule // dwc_host_model

//--- tb/drive_and_wake_config_reg_tb.sv
`timescale 1ns/1ps
`include "dwc_consts.svh"
// ========================================
// self-checking bench for the drive and wake register
module drive_and_wake_config_reg_tb;
   // written byte beside expected read-back and select
   typedef struct packed
   {
      logic [7:0] data;
      logic [7:0] expRd;
      logic [2:0] expSel;
   } dwc_row_s;
   logic        ref_clk       = 1'b0;
   logic        rst_n         = 1'b0;
   logic        hwResetPinN   = 1'b1;
   logic        busResetReq   = 1'b0;
   logic        softResetReq  = 1'b0;
   logic        hibernateExit = 1'b0;
   logic [7:0]  nvImage       = `DWC_FACTORY;  // factory image
   logic        csPinN;
   logic        wrStrobe;
   logic [23:0] wrAddr;
   logic [7:0]  wrData;
   logic [7:0]  rdData;
   logic [2:0]  driveStrengthSelect;
   logic        deepSleep;
   logic        standby;
   int          numErrors  = 0;
   int          nChecks    = 0;
   int          cycleCount = 0;
   int          n;
   // junk in bits 4,1,0 must never read back
   dwc_row_s    rows [8] = '{'{8'h13, 8'h08, 3'h0}, '{8'h37, 8'h2C, 3'h1}, '{8'h40, 8'h48, 3'h2},
                             '{8'h75, 8'h6C, 3'h3}, '{8'h92, 8'h88, 3'h4}, '{8'hA4, 8'hAC, 3'h5},
                             '{8'hD1, 8'hC8, 3'h6}, '{8'hFF, 8'hEC, 3'h7}};
   always #12.5 ref_clk = ~ref_clk;  // 40 MHz
   dwc_host_model i_host
   (
      .ref_clk  (ref_clk),
      .csPinN   (csPinN),
      .wrStrobe (wrStrobe),
      .wrAddr   (wrAddr),
      .wrData   (wrData)
   );
   dwc_config_reg i_dut
   (
      .ref_clk             (ref_clk),
      .rst_n               (rst_n),
      .csPinN              (csPinN),
      .hwResetPinN         (hwResetPinN),
      .busResetReq         (busResetReq),
      .softResetReq        (softResetReq),
      .hibernateExit       (hibernateExit),
      .wrStrobe            (wrStrobe),
      .wrAddr              (wrAddr),
      .wrData              (wrData),
      .nvImage             (nvImage),
      .rdData              (rdData),
      .driveStrengthSelect (driveStrengthSelect),
      .deepSleep           (deepSleep),
      .standby             (standby)
   );
   // ========================================
   // compare, count, report at once
   task automatic checkByte(input logic [7:0] got, input logic [7:0] exp);
      nChecks++;
      if (got !== exp)
      begin
         numErrors++;
         $display("unexpected at %0t: got %0h expected %0h", $time, got, exp);
      end
   endtask
   task automatic completeRun;
      $display("checks %0d errors %0d", nChecks, numErrors);
      if (numErrors == 0 && nChecks > 0)
         $display("Result: passed");
      else
         $display("Result: failed");
      $finish;
   endtask
   // one-cycle decoder pulse: 0 bus reset, 1 soft reset, 2 hibernate exit
   task automatic pulseEvent(input int sel);
      @(posedge ref_clk);
      busResetReq   <= (sel == 0);
      softResetReq  <= (sel == 1);
      hibernateExit <= (sel == 2);
      @(posedge ref_clk);
      busResetReq   <= 1'b0;
      softResetReq  <= 1'b0;
      hibernateExit <= 1'b0;
      @(negedge ref_clk);
   endtask
   // bounded wait, so latency slack never hides a wrong state
   task automatic checkPower(input logic expSleep, input logic expStby, input int limit);
      int k;
      k = 0;
      while (k < limit && {deepSleep, standby} !== {expSleep, expStby})
      begin
         @(negedge ref_clk);
         k++;
      end
      checkByte({6'h00, deepSleep, standby}, {6'h00, expSleep, expStby});
   endtask
   // hang guard, run needs about nine hundred cycles
   always @(posedge ref_clk)
   begin
      cycleCount++;
      if (cycleCount == 2000)
      begin
         numErrors++;
         completeRun();
      end
   end
   // ========================================
   // main sequence
   initial
   begin
      repeat (2) @(posedge ref_clk);
      rst_n <= 1'b1;
      checkPower(1'b0, 1'b1, 3);
      checkByte(rdData, `DWC_FACTORY);
      checkByte({5'h00, driveStrengthSelect}, 8'h00);
      foreach (rows[i])
      begin
         i_host.writeReg(`DWC_ADDR_VOL, rows[i].data);
         @(negedge ref_clk);
         checkByte(rdData, rows[i].expRd);
         checkByte({5'h00, driveStrengthSelect}, {5'h00, rows[i].expSel});
      end
      // nonvolatile address leaves the volatile copy alone
      i_host.writeReg(`DWC_ADDR_NV, 8'h00);
      @(negedge ref_clk);
      checkByte(rdData, 8'hEC);
      // bus reset reloads the copy, so the sleep choice follows the nonvolatile image
      @(posedge ref_clk);
      nvImage <= 8'h2C;
      pulseEvent(0);
      checkPower(1'b1, 1'b0, 3);
      checkByte(rdData, 8'h2C);
      i_host.writeReg(`DWC_ADDR_VOL, 8'h00);
      @(posedge ref_clk);
      nvImage <= `DWC_FACTORY;
      pulseEvent(0);
      checkPower(1'b0, 1'b1, 3);
      i_host.writeReg(`DWC_ADDR_VOL, 8'hE4);
      pulseEvent(2);
      checkPower(1'b1, 1'b0, 3);
      pulseEvent(1);
      checkPower(1'b0, 1'b1, 3);
      pulseEvent(2);
      checkPower(1'b1, 1'b0, 3);
      // a pulse one cycle short of the width must not wake
      i_host.wakePulse(`DWC_WAKE_CYC - 1);
      repeat (6) @(negedge ref_clk);
      checkPower(1'b1, 1'b0, 1);
      // exactly the minimum width wakes
      i_host.wakePulse(`DWC_WAKE_CYC);
      checkPower(1'b0, 1'b0, 6);
      n = 0;
      while (standby !== 1'b1 && n < `DWC_EXIT_CYC + 20)
      begin
         @(negedge ref_clk);
         n++;
      end
      checkByte({7'h00, n >= `DWC_EXIT_CYC - 10 && n <= `DWC_EXIT_CYC + 10}, 8'h01);
      // hardware reset reloads the copy and honours its sleep bit
      @(posedge ref_clk);
      nvImage     <= 8'h2C;
      hwResetPinN <= 1'b0;
      repeat (4) @(posedge ref_clk);
      hwResetPinN <= 1'b1;
      checkPower(1'b1, 1'b0, 8);
      checkByte(rdData, 8'h2C);
      // reset pin while asleep wakes through the exit time
      @(posedge ref_clk);
      hwResetPinN <= 1'b0;
      repeat (4) @(posedge ref_clk);
      hwResetPinN <= 1'b1;
      checkPower(1'b0, 1'b0, 6);
      checkPower(1'b0, 1'b1, `DWC_EXIT_CYC + 10);
      completeRun();
   end
endmodule // drive_and_wake_config_reg_tb
